// ==== i2c_scl_timing_generator.sv ====
/*
 Clock and start/stop phase generator of the two-wire serial unit.
 Assumes requests are one-cycle pulses synchronous to clock_i and that
 the pins are open drain, pulled high outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_timing_regs.svh"
module i2c_scl_timing_generator
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [1:0] div_sel_i,
   input wire logic start_req_i,
   input wire logic stop_req_i,
   input wire logic service_set_i,
   input wire logic data_bit_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   output logic busy_o,
   output logic word_done_o,
   output logic scl_level_o
);
   import i2c_timing_pkg::*;

   logic rst_n;
   logic rst_meta_q;
   logic rst_sync_q;
   logic scl_qual;
   i2c_timing_pkg::tgen_state_e state_q, state_d;
   i2c_timing_pkg::count_t cnt_q, cnt_d;
   i2c_timing_pkg::count_t m_cnt, n_cnt;
   logic [3:0] bits_q;
   logic stop_pend_q;

   // ----------------------------------------
   // Phase counts from the divider setting
   // ----------------------------------------
   function automatic count_t high_count(input logic [1:0] sel);
      high_count = `HIGH_BASE_CYC << sel;
   endfunction : high_count

   function automatic count_t low_count(input logic [1:0] sel);
      low_count = `LOW_BASE_CYC << sel;
   endfunction : low_count

   function automatic logic pulls_scl(input tgen_state_e st);
      pulls_scl = (st == ST_LOW) || (st == ST_HOLD) || (st == ST_SERVICE) ||
                  (st == ST_STOP_LOW);
   endfunction : pulls_scl

   assign m_cnt = high_count(div_sel_i);
   assign n_cnt = low_count(div_sel_i);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   scl_phase_filter u_filter
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .scl_i(scl_i),
      .scl_qual_o(scl_qual)
   );

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + 16'h0001;
      case (state_q)
         ST_IDLE:
         begin
            cnt_d = 16'h0000;
            if (start_req_i)
               state_d = ST_START;
         end
         ST_START:
            if (cnt_q == m_cnt - 16'h0001)
            begin
               state_d = ST_LOW;
               cnt_d = 16'h0000;
            end
         ST_LOW:
            if (cnt_q == n_cnt - 16'h0001)
            begin
               state_d = ST_HIGH;
               cnt_d = 16'h0000;
            end
         ST_HIGH:
         begin
            if (!scl_qual)
               cnt_d = 16'h0000;
            else if (cnt_q == m_cnt - 16'h0001)
            begin
               cnt_d = 16'h0000;
               state_d = (bits_q == `BITS_PER_WORD - 4'h1) ? ST_HOLD : ST_LOW;
            end
         end
         ST_HOLD:
         begin
            cnt_d = 16'h0000;
            if (service_set_i)
               state_d = ST_SERVICE;
         end
         ST_SERVICE:
            if (cnt_q == n_cnt - 16'h0001)
            begin
               state_d = stop_pend_q ? ST_STOP_LOW : ST_LOW;
               cnt_d = 16'h0000;
            end
         ST_STOP_LOW:
            if (cnt_q == n_cnt - 16'h0001)
            begin
               state_d = ST_STOP_HIGH;
               cnt_d = 16'h0000;
            end
         ST_STOP_HIGH:
         begin
            if (!scl_qual)
               cnt_d = 16'h0000;
            else if (cnt_q == m_cnt - 16'h0001)
            begin
               state_d = ST_IDLE;
               cnt_d = 16'h0000;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
            cnt_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------
   // Bit count and stop request
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         bits_q <= 4'h0;
      else if (state_q == ST_HOLD || state_q == ST_IDLE)
         bits_q <= 4'h0;
      else if (state_q == ST_HIGH && state_d != ST_HIGH)
         bits_q <= bits_q + 4'h1;
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         stop_pend_q <= 1'b0;
      else if (state_q == ST_HOLD && stop_req_i)
         stop_pend_q <= 1'b1;
      else if (state_q == ST_IDLE)
         stop_pend_q <= 1'b0;
   end

   // ----------------------------------------
   // Pin and status outputs
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         busy_o <= 1'b0;
         word_done_o <= 1'b0;
         scl_level_o <= 1'b1;
      end
      else
      begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= pulls_scl(state_d);
         if (state_d == ST_START || state_d == ST_STOP_LOW || state_d == ST_STOP_HIGH)
            sda_oe_o <= 1'b1;
         else if (state_d == ST_LOW && state_q != ST_LOW)
            sda_oe_o <= ~data_bit_i;
         else if (state_d == ST_IDLE || state_d == ST_HOLD)
            sda_oe_o <= 1'b0;
         busy_o <= (state_d != ST_IDLE);
         word_done_o <= (state_d == ST_HOLD) && (state_q != ST_HOLD);
         scl_level_o <= scl_qual;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_LOW_PHASE: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q != ST_LOW && state_d == ST_LOW) |=> scl_oe_o [*8])
      else $error("Clock low phase length wrong");

   AST_HIGH_PHASE: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q != ST_HIGH && state_d == ST_HIGH) |=> (!scl_oe_o) [*6])
      else $error("Clock high phase length wrong");

   AST_START_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q == ST_IDLE && start_req_i) |=> sda_oe_o && !scl_oe_o
         ##1 (!scl_oe_o && state_q == ST_START)[*3])
      else $error("Start hold broken");

   AST_STOP_SETUP: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q == ST_STOP_HIGH && state_d == ST_IDLE)
         |-> scl_qual && cnt_q == m_cnt - 16'h0001 ##1 !sda_oe_o)
      else $error("Stop setup too short");

   AST_SERVICE_LOW: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q == ST_HOLD && service_set_i) |=> scl_oe_o [*5])
      else $error("Clock rose too soon after service flag");

   AST_STRETCH: assert property (@(posedge clock_i) disable iff (!rst_n)
      (state_q == ST_STOP_HIGH && !scl_qual) |=> state_q == ST_STOP_HIGH && cnt_q == 16'h0000)
      else $error("Stop issued while clock held low");

   AST_DIVIDER: assert property (@(posedge clock_i) disable iff (!rst_n)
      $changed(div_sel_i) |-> m_cnt == (`HIGH_BASE_CYC << div_sel_i))
      else $error("High count not taken from divider");

   AST_SCL_DRIVE: assert property (@(posedge clock_i) disable iff (!rst_n)
      scl_oe_o |-> pulls_scl(state_q) && !scl_o)
      else $error("Clock driven outside a low phase");
endmodule : i2c_scl_timing_generator
`default_nettype wire

// ==== i2c_timing_regs.svh ====
/*
 Timing constants of the two-wire serial unit clock generator.
 Assumes one gear clock of 100 MHz drives every counter.
*/
// Overview of operation
// - As master the unit holds every low phase but the word-end hold for n gear cycles, so the bus clock is the gear clock over m plus n plus 4 filter cycles.
// - As master the unit leaves every released clock high phase for m gear cycles after the filter accepts the high level.
// - After a start condition the unit waits m gear cycles before it pulls the clock low for the first pulse.
// - For a stop the unit keeps the clock high for m gear cycles after the filter accepts it before it releases the data line.
// - After the service flag goes from zero to one the clock stays low for 2n more gear cycles before it rises.
// - If another party holds the clock low at a stop, the unit waits for release and stops one high phase later.
`ifndef I2C_TIMING_REGS_SVH
`define I2C_TIMING_REGS_SVH

`define CLK_PERIOD_NS 10
`define HIGH_BASE_CYC 16'h0006
`define LOW_BASE_CYC 16'h0008
`define SCL_LOW_MIN_CYC 3'h5
`define SCL_HIGH_MIN_CYC 3'h3
`define BITS_PER_WORD 4'h9

`endif

// ==== i2c_timing_pkg.sv ====
/*
 Types of the two-wire serial unit clock generator.
 Assumes the constants header is compiled alongside.
*/
package i2c_timing_pkg;
   typedef logic [15:0] count_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b011,
      ST_HOLD = 3'b100,
      ST_SERVICE = 3'b101,
      ST_STOP_LOW = 3'b110,
      ST_STOP_HIGH = 3'b111
   } tgen_state_e;
endpackage : i2c_timing_pkg

// ==== scl_phase_filter.sv ====
/*
 Qualifies the sampled clock line: a new level is accepted only after it
 has stood for its minimum count of gear cycles.
 Assumes the line input is already synchronous to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_timing_regs.svh"
module scl_phase_filter
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   output logic scl_qual_o
);
   logic raw_q;
   logic [2:0] run_q;

   // ----------------------------------------
   // Sample and qualify
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         raw_q <= 1'b1;
         run_q <= 3'h0;
         scl_qual_o <= 1'b1;
      end
      else
      begin
         raw_q <= scl_i;
         if (raw_q == scl_qual_o)
            run_q <= 3'h0;
         else if ((!raw_q && run_q == `SCL_LOW_MIN_CYC - 3'h1) ||
                  (raw_q && run_q == `SCL_HIGH_MIN_CYC - 3'h1))
         begin
            scl_qual_o <= raw_q;
            run_q <= 3'h0;
         end
         else
            run_q <= run_q + 3'h1;
      end
   end

   AST_LOW_QUAL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $fell(scl_qual_o) |-> !$past(raw_q, 5))
      else $error("Clock low accepted too early");
endmodule : scl_phase_filter
`default_nettype wire

// ==== far_bus_model.sv ====
/*
 Far side of the two-wire bus: the pull-up and a party that can stretch
 the clock line. Assumes an enable input high pulls the line low.
*/
`timescale 1ns/10ps
`default_nettype none
module far_bus_model
(
   input wire logic clock_i,
   input wire logic scl_oe_i,
   input wire logic stretch_i,
   output logic scl_line_o
);
   logic [2:0] keep_q;
   // -----------------
   // Stretch hold
   // -----------------
   always @(posedge clock_i)
   begin
      if (stretch_i)
         keep_q <= 3'h5;
      else if (keep_q != 3'h0 && keep_q !== 3'hX)
         keep_q <= keep_q - 3'h1;
      else
         keep_q <= 3'h0;
   end
   assign scl_line_o = ~(scl_oe_i | stretch_i | (keep_q > 3'h0));
endmodule : far_bus_model
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench of the clock phase generator.
 Assumes the far bus model and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_timing_regs.svh"
module tb_top;
   typedef struct {logic [1:0] sel; int m; int n;} row_s;
   row_s rows[4];
   localparam int FREE_CYC = 470;
   logic clock_i, resetn_i, start_req_i, stop_req_i, service_set_i, data_bit_i;
   logic stretch, scl_line, oe_prev, sda_prev;
   logic [1:0] div_sel_i;
   logic scl_o, scl_oe_o, sda_o, sda_oe_o, busy_o, word_done_o, scl_level_o;
   int fail_count, checks_done, lo_run, hi_run, hold_run, su_run;
   int last_lo, last_hi, last_hold, last_su, wd_cnt;

   i2c_scl_timing_generator u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
      .div_sel_i(div_sel_i), .start_req_i(start_req_i), .stop_req_i(stop_req_i),
      .service_set_i(service_set_i), .data_bit_i(data_bit_i), .scl_i(scl_line),
      .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .busy_o(busy_o), .word_done_o(word_done_o), .scl_level_o(scl_level_o));
   far_bus_model u_far (.clock_i(clock_i), .scl_oe_i(scl_oe_o),
      .stretch_i(stretch), .scl_line_o(scl_line));

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // -----------------
   // Phase measurement
   // -----------------
   always @(posedge clock_i)
   begin
      lo_run <= scl_oe_o ? lo_run + 1 : 0;
      hi_run <= (!scl_oe_o && scl_line) ? hi_run + 1 : 0;
      hold_run <= (sda_oe_o && !scl_oe_o) ? hold_run + 1 : 0;
      su_run <= (sda_oe_o && !scl_oe_o && scl_line) ? su_run + 1 : 0;
      if (oe_prev && !scl_oe_o)
         last_lo <= lo_run;
      if (!oe_prev && scl_oe_o)
         last_hi <= hi_run;
      if (!oe_prev && scl_oe_o)
         last_hold <= hold_run;
      if (sda_prev && !sda_oe_o)
         last_su <= su_run;
      if (word_done_o)
         wd_cnt <= wd_cnt + 1;
      oe_prev <= scl_oe_o;
      sda_prev <= sda_oe_o;
   end
   // -----------------
   // Checks
   // -----------------
   task check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_bit
   task check_min(input int got, input int lim);
      checks_done++;
      if (got < lim)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h min=%h", $time, got, lim);
      end
   endtask : check_min
   task check_eq(input int got, input int exp);
      checks_done++;
      if (got != exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_eq
   task wait_for(input int s, input logic v);
      int k;
      k = 0;
      while ((s == 0 ? scl_oe_o : s == 1 ? busy_o : sda_oe_o) !== v && k < 3000)
      begin
         @(negedge clock_i);
         k++;
      end
      check_min(2999, k);
   endtask : wait_for
   task stop_test;
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   task run_word(input int m, input int n, input int hold_low);
      int k;
      int w0;
      w0 = wd_cnt;
      repeat (FREE_CYC) @(negedge clock_i);
      start_req_i = 1'b1;
      @(negedge clock_i);
      start_req_i = 1'b0;
      for (k = 0; k < 10; k++)
      begin
         data_bit_i = k[0];
         wait_for(0, 1'b1);
         repeat (2) @(negedge clock_i);
         if (k == 0)
            check_eq(last_hold, m);
         else
            check_min(last_hi, m);
         if (k < 9)
         begin
            wait_for(0, 1'b0);
            @(negedge clock_i);
            check_eq(last_lo, n);
            check_bit(sda_oe_o, ~data_bit_i);
            check_bit(scl_o | sda_o, 1'b0);
         end
      end
      check_eq(wd_cnt, w0 + 1);
      stop_req_i = 1'b1;
      @(negedge clock_i);
      stop_req_i = 1'b0;
      service_set_i = 1'b1;
      @(negedge clock_i);
      service_set_i = 1'b0;
      k = 1;
      while (scl_oe_o === 1'b1 && k < 3000)
      begin
         @(negedge clock_i);
         k++;
      end
      check_min(k, 2 * n);
      stretch = (hold_low > 0);
      repeat (hold_low) @(negedge clock_i);
      check_bit(busy_o, 1'b1);
      check_bit(sda_oe_o, 1'b1);
      check_bit(scl_level_o, 1'b0);
      stretch = 1'b0;
      wait_for(1, 1'b0);
      @(negedge clock_i);
      check_min(last_su, m);
      check_bit(sda_oe_o, 1'b0);
   endtask : run_word

   initial
   begin
      repeat (60000) @(posedge clock_i);
      fail_count++;
      stop_test();
   end
   initial
   begin
      {start_req_i, stop_req_i, service_set_i, data_bit_i, stretch} = 5'h00;
      div_sel_i = 2'h0;
      resetn_i = 1'b0;
      for (int i = 0; i < 4; i++)
         rows[i] = '{2'(i), int'(`HIGH_BASE_CYC) << i, int'(`LOW_BASE_CYC) << i};
      repeat (6) @(negedge clock_i);
      check_bit(scl_oe_o | sda_oe_o | busy_o, 1'b0);
      check_bit(scl_level_o, 1'b1);
      resetn_i = 1'b1;
      repeat (3) @(negedge clock_i);
      stop_req_i = 1'b1;
      @(negedge clock_i);
      stop_req_i = 1'b0;
      repeat (2) @(negedge clock_i);
      check_bit(busy_o, 1'b0);
      foreach (rows[i])
      begin
         div_sel_i = rows[i].sel;
         run_word(rows[i].m, rows[i].n, 0);
      end
      div_sel_i = 2'h0;
      run_word(6, 8, 30);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
